// ===== src/mpls_egress_label_editor.sv
// Egress label editor: pop, table lookup, push and remark per frame copy.
`timescale 1ns/100ps
// What this block does
// - Each copy runs rule lookup, pop, table lookup, push, then remark, in order.
// - On a rule miss only popping happens; no push and no remark.
// - Old link header and label stack are removed before new encapsulation.
// - Pop count is rule count if non-zero, never above classifier count.
// - At most 42 bytes can be popped.
// - Table indexed by encapsulation index; index zero is never valid.
// - Lookup yields both the new encapsulation and its remark settings.
// - 128 entries hold split destination and source MAC plus link ethertype.
// - Push prepends a new link header and label stack from the entry.
// - Each entry pushes zero to three labels.
// - Inner label source option takes the innermost label from the rule.
// - Control word enable inserts the entry's control word after the stack.
// - Each entry holds label, class, bottom bit and lifetime per label.
// - Label select 0 fixed, 1-3 reserved, 4-7 mapping tables 0-3.
// - Extra label is added for TP OAM payloads, or Ethernet OAM with a control word after the pop, when enabled and no control word.
// - Extra label position 0 before last label, 1 after last label.
// - Extra label fields come from the entry's extra label values.
// - Extra label class: classified, fixed, or mapped with fallbacks.
// - Remark rewrites pushed label fields per the entry's remark settings.
module mpls_egress_label_editor (
   input  wire logic                             i_ref_clk,
   input  wire logic                             i_sys_rst,
   input  wire logic                             i_psel,
   input  wire logic                             i_penable,
   input  wire logic                             i_pwrite,
   input  wire logic        [13:0]               i_paddr,
   input  wire logic        [31:0]               i_pwdata,
   output logic             [31:0]               o_prdata,
   output logic                                  o_pready,
   output logic                                  o_pslverr,
   input  wire logic                             i_req_valid,
   input  wire mpls_edit_pkg::edit_req_t         i_req,
   input  wire mpls_edit_pkg::map_result_t       i_map,
   output logic                                  o_req_ready,
   output logic                                  o_res_valid,
   output mpls_edit_pkg::edit_res_t              o_res,
   input  wire logic                             i_res_ready
);
   // ==========================================================
   // Encapsulation table and control state
   logic [31:0] table_mem [0:mpls_edit_pkg::TABLE_WORDS-1];
   logic [31:0] ctrl_reg;
   logic [15:0] edit_count_reg;
   logic [15:0] miss_count_reg;
   logic [31:0] prdata_reg;
   logic        slverr_reg;

   // ==========================================================
   // APB slave
   logic                 in_table;
   logic [6:0]           bus_idx;
   logic [3:0]           bus_word;
   logic                 bus_mapped;
   logic                 bus_zero_idx;
   logic                 bus_write;
   logic [31:0]          wr_mask;

   assign in_table     = ~i_paddr[13];
   assign bus_idx      = i_paddr[12:6];
   assign bus_word     = i_paddr[5:2];
   assign bus_zero_idx = in_table && (bus_idx == mpls_edit_pkg::IDX_UNUSABLE);
   assign bus_mapped   = (in_table && (bus_word < mpls_edit_pkg::REG_COUNT))
                         || (i_paddr == mpls_edit_pkg::ADDR_CTRL)
                         || (i_paddr == mpls_edit_pkg::ADDR_STATUS);
   assign bus_write    = i_psel && i_penable && i_pwrite && bus_mapped && !bus_zero_idx;
   assign o_pready     = i_psel && i_penable;
   assign o_prdata     = prdata_reg;
   assign o_pslverr    = o_pready && slverr_reg;

   always_comb begin
      case (bus_word)
         mpls_edit_pkg::REG_DMAC_HI: wr_mask = mpls_edit_pkg::MASK_HALF;
         mpls_edit_pkg::REG_SMAC_HI: wr_mask = mpls_edit_pkg::MASK_HALF;
         mpls_edit_pkg::REG_ETYPE:   wr_mask = mpls_edit_pkg::MASK_HALF;
         default:                    wr_mask = mpls_edit_pkg::MASK_FULL;
      endcase
   end

   // The table has no reset; software programs every entry before use.
   always_ff @(posedge i_ref_clk) begin
      if (bus_write && in_table) begin
         table_mem[{bus_idx, bus_word}] <= i_pwdata & wr_mask;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ctrl_reg <= mpls_edit_pkg::CTRL_RESET;
      end else if (bus_write && (i_paddr == mpls_edit_pkg::ADDR_CTRL)) begin
         ctrl_reg <= i_pwdata;
      end
   end

   // Read data is captured in the setup cycle, so every access completes in one access cycle.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         prdata_reg <= '0;
         slverr_reg <= 1'b0;
      end else if (i_psel && !i_penable) begin
         slverr_reg <= !bus_mapped || bus_zero_idx;
         if (!bus_mapped || i_pwrite) begin
            prdata_reg <= '0;
         end else if (in_table) begin
            prdata_reg <= table_mem[{bus_idx, bus_word}];
         end else if (i_paddr == mpls_edit_pkg::ADDR_CTRL) begin
            prdata_reg <= ctrl_reg;
         end else begin
            prdata_reg <= {miss_count_reg, edit_count_reg};
         end
      end
   end

   // ==========================================================
   // Rule lookup and popping
   logic                 accept;
   logic                 hit;
   logic [4:0]           pop_words;
   logic [4:0]           pop_pick;

   assign o_req_ready = !o_res_valid || i_res_ready;
   assign accept      = i_req_valid && o_req_ready;
   assign hit         = i_req.rule_hit && ctrl_reg[mpls_edit_pkg::CTRL_ENA_BIT]
                        && (i_req.encapsulation_index != mpls_edit_pkg::IDX_UNUSABLE);

   always_comb begin
      if ((i_req.rule_pop_count != '0) && (i_req.rule_pop_count < i_req.classifier_pop_count)) begin
         pop_pick = i_req.rule_pop_count;
      end else begin
         pop_pick = i_req.classifier_pop_count;
      end
      if (pop_pick > mpls_edit_pkg::MAX_POP_WORDS) begin
         pop_words = mpls_edit_pkg::MAX_POP_WORDS;
      end else begin
         pop_words = pop_pick;
      end
   end

   // ==========================================================
   // Table lookup
   logic [6:0]           idx;
   logic [31:0]          stack_cfg;
   logic [31:0]          extra_cfg;
   logic [31:0]          extra_val;
   logic [1:0]           pushed_label_count;
   logic                 control_word_insert_enable;
   logic [2:0][31:0]     encap_label_values;
   logic [2:0][31:0]     remark_sel;
   logic [2:0][31:0]     built;

   assign idx       = i_req.encapsulation_index;
   assign stack_cfg = table_mem[{idx, mpls_edit_pkg::REG_STACK_CFG}];
   assign extra_cfg = table_mem[{idx, mpls_edit_pkg::REG_EXTRA_CFG}];
   assign extra_val = table_mem[{idx, mpls_edit_pkg::REG_EXTRA_VAL}];
   assign pushed_label_count = stack_cfg[mpls_edit_pkg::STK_CNT_LSB +: 2];
   assign control_word_insert_enable    = stack_cfg[mpls_edit_pkg::STK_CW_BIT];

   // ==========================================================
   // Label construction and remark
   genvar g;
   generate
      for (g = 0; g < mpls_edit_pkg::LABEL_MAX; g++) begin : gen_label
         assign encap_label_values[g]  = table_mem[{idx, 4'(mpls_edit_pkg::REG_LABEL_VAL0 + 4'(g))}];
         assign remark_sel[g] = table_mem[{idx, 4'(mpls_edit_pkg::REG_REMARK0 + 4'(g))}];
         label_builder u_label (
            .i_value       (encap_label_values[g]),
            .i_select      (remark_sel[g][2:0]),
            .i_map_label   (i_map.map_label),
            .i_inner_use   (stack_cfg[mpls_edit_pkg::STK_INNER_BIT] && (pushed_label_count == 2'(g + 1))),
            .i_inner_label (i_req.inner_label),
            .o_label       (built[g])
         );
      end
   endgenerate

   // ==========================================================
   // Extra label
   logic                 extra_use;
   logic [2:0]           extra_tc;
   logic [2:0]           fixed_tc;
   logic [31:0]          extra_label;

   assign extra_use = extra_cfg[mpls_edit_pkg::EXT_ENA_BIT] && !control_word_insert_enable
                      && ((i_req.payload_unit_type == mpls_edit_pkg::PDU_TP_OAM)
                          || ((i_req.payload_unit_type == mpls_edit_pkg::PDU_ETH_OAM)
                              && i_req.after_pop_is_control_word));
   assign fixed_tc  = extra_val[mpls_edit_pkg::LBL_TC_LSB +: 3];

   always_comb begin
      case (extra_cfg[mpls_edit_pkg::EXT_TC_LSB +: 3])
         mpls_edit_pkg::SEL_FIXED_TC: extra_tc = fixed_tc;
         mpls_edit_pkg::SEL_MAP0: extra_tc = i_map.map_tc_hit[0] ? i_map.map_tc[0] : fixed_tc;
         mpls_edit_pkg::SEL_MAP1: extra_tc = i_map.map_tc_hit[1] ? i_map.map_tc[1] : i_map.map_tc[0];
         mpls_edit_pkg::SEL_MAP2: extra_tc = i_map.map_tc_hit[2] ? i_map.map_tc[2] : fixed_tc;
         mpls_edit_pkg::SEL_MAP3: extra_tc = i_map.map_tc_hit[3] ? i_map.map_tc[3] : i_map.map_tc[2];
         default: extra_tc = i_req.classified_tc;
      endcase
      extra_label = extra_val;
      extra_label[mpls_edit_pkg::LBL_TC_LSB +: 3] = extra_tc;
   end

   // ==========================================================
   // Stack assembly
   logic [3:0][31:0]     stack;
   logic [2:0]           depth;

   always_comb begin
      stack = '0;
      depth = '0;
      for (int i = 0; i < mpls_edit_pkg::LABEL_MAX; i++) begin
         if (2'(i) < pushed_label_count) begin
            if (extra_use && !extra_cfg[mpls_edit_pkg::EXT_POS_BIT] && (2'(i + 1) == pushed_label_count)) begin
               stack[depth[1:0]] = extra_label;
               depth             = depth + 3'h1;
            end
            stack[depth[1:0]] = built[i];
            depth             = depth + 3'h1;
         end
      end
      // With no labels there is no last label, so the extra one simply becomes the stack.
      if (extra_use && (extra_cfg[mpls_edit_pkg::EXT_POS_BIT] || (pushed_label_count == 2'h0))) begin
         stack[depth[1:0]] = extra_label;
         depth             = depth + 3'h1;
      end
   end

   // ==========================================================
   // Result register
   mpls_edit_pkg::edit_res_t res_next;

   always_comb begin
      res_next           = '0;
      res_next.pop_bytes = {pop_words, 1'b0};
      if (hit) begin
         res_next.push_valid   = 1'b1;
         res_next.dmac         = {table_mem[{idx, mpls_edit_pkg::REG_DMAC_HI}][15:0],
                                  table_mem[{idx, mpls_edit_pkg::REG_DMAC_LO}]};
         res_next.smac         = {table_mem[{idx, mpls_edit_pkg::REG_SMAC_HI}][15:0],
                                  table_mem[{idx, mpls_edit_pkg::REG_SMAC_LO}]};
         res_next.etype        = table_mem[{idx, mpls_edit_pkg::REG_ETYPE}][15:0];
         res_next.label_count  = depth;
         res_next.labels       = stack;
         res_next.cw_valid     = control_word_insert_enable;
         res_next.control_word = control_word_insert_enable ? table_mem[{idx, mpls_edit_pkg::REG_ENCAP_CONTROL_WORD_VALUE}] : '0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_res_valid <= 1'b0;
         o_res       <= '0;
      end else if (accept) begin
         o_res_valid <= 1'b1;
         o_res       <= res_next;
      end else if (i_res_ready) begin
         o_res_valid <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         edit_count_reg <= '0;
         miss_count_reg <= '0;
      end else if (accept && hit) begin
         edit_count_reg <= edit_count_reg + 16'h0001;
      end else if (accept) begin
         miss_count_reg <= miss_count_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_accept;
      i_req_valid && o_req_ready;
   endsequence
   sequence s_miss;
      s_accept ##0 !i_req.rule_hit;
   endsequence
   sequence s_stall;
      o_res_valid && !i_res_ready;
   endsequence

   a_miss_no_push: assert property (s_miss |=> o_res_valid && !o_res.push_valid && (o_res.label_count == '0))
      else $error("Push seen after a rule miss.");
   a_index_zero_miss: assert property (s_accept ##0 (i_req.encapsulation_index == '0) |=> !o_res.push_valid)
      else $error("Index zero produced an encapsulation.");
   a_pop_limit: assert property (o_res_valid |-> o_res.pop_bytes <= 6'(mpls_edit_pkg::MAX_POP_BYTES))
      else $error("Pop length above the limit.");
   a_pop_not_above: assert property (s_accept |=> o_res.pop_bytes <= {$past(i_req.classifier_pop_count), 1'b0})
      else $error("Pop exceeds classifier count.");
   a_pop_default: assert property (s_accept ##0 (i_req.rule_pop_count == '0)
         && (i_req.classifier_pop_count <= mpls_edit_pkg::MAX_POP_WORDS)
         |=> o_res.pop_bytes == {$past(i_req.classifier_pop_count), 1'b0})
      else $error("Classifier pop count not used.");
   a_label_depth: assert property (o_res_valid |-> o_res.label_count <= 3'(mpls_edit_pkg::LABEL_MAX + 1))
      else $error("Too many pushed labels.");
   a_cw_needs_push: assert property (o_res_valid && o_res.cw_valid |-> o_res.push_valid)
      else $error("Control word without push.");
   a_extra_no_cw: assert property (s_accept ##0 hit && control_word_insert_enable
         |=> o_res.label_count == 3'($past(pushed_label_count)))
      else $error("Extra label added with control word.");
   a_result_hold: assert property (s_stall |=> o_res_valid && $stable(o_res))
      else $error("Result changed while stalled.");
   a_zero_write: assert property (i_psel && i_penable && in_table && (bus_idx == '0) |-> o_pslverr)
      else $error("Write to index zero not refused.");
endmodule

// ===== src/mpls_edit_pkg.sv
// Shared constants, codes and carrier types for the egress label editor.
package mpls_edit_pkg;
   // ==========================================================
   // Table geometry and limits
   localparam int          ENTRY_COUNT    = 128;
   localparam int          IDX_W          = 7;
   localparam int          REG_W          = 4;
   localparam int          TABLE_WORDS    = ENTRY_COUNT * 16;
   localparam int          LABEL_MAX      = 3;
   localparam int          MAX_POP_BYTES  = 42;
   localparam logic [4:0]  MAX_POP_WORDS  = 5'(MAX_POP_BYTES / 2);
   localparam logic [6:0]  IDX_UNUSABLE   = 7'h00;
   // ==========================================================
   // Register map: entry n, word r sits at byte n*64 + r*4
   localparam logic [3:0]  REG_DMAC_HI    = 4'h0;
   localparam logic [3:0]  REG_DMAC_LO    = 4'h1;
   localparam logic [3:0]  REG_SMAC_HI    = 4'h2;
   localparam logic [3:0]  REG_SMAC_LO    = 4'h3;
   localparam logic [3:0]  REG_ETYPE      = 4'h4;
   localparam logic [3:0]  REG_STACK_CFG  = 4'h5;
   localparam logic [3:0]  REG_EXTRA_CFG  = 4'h6;
   localparam logic [3:0]  REG_ENCAP_CONTROL_WORD_VALUE     = 4'h7;
   localparam logic [3:0]  REG_LABEL_VAL0 = 4'h8;
   localparam logic [3:0]  REG_EXTRA_VAL  = 4'hb;
   localparam logic [3:0]  REG_REMARK0    = 4'hc;
   localparam logic [3:0]  REG_COUNT      = 4'hf;
   localparam logic [13:0] ADDR_CTRL      = 14'h2000;
   localparam logic [13:0] ADDR_STATUS    = 14'h2004;
   localparam logic [31:0] MASK_HALF      = 32'h0000ffff;
   localparam logic [31:0] MASK_FULL      = 32'hffffffff;
   localparam logic [31:0] CTRL_RESET     = 32'h00000001;
   // ==========================================================
   // Field positions
   localparam int          CTRL_ENA_BIT   = 0;
   localparam int          STK_INNER_BIT  = 0;
   localparam int          STK_CNT_LSB    = 1;
   localparam int          STK_CW_BIT     = 3;
   localparam int          EXT_ENA_BIT    = 0;
   localparam int          EXT_POS_BIT    = 1;
   localparam int          EXT_TC_LSB     = 2;
   localparam int          LBL_VAL_LSB    = 12;
   localparam int          LBL_TC_LSB     = 9;
   // ==========================================================
   // Selector codes
   localparam logic [2:0]  SEL_CODE0      = 3'h0;
   localparam logic [2:0]  SEL_FIXED_TC   = 3'h1;
   localparam logic [2:0]  SEL_MAP0       = 3'h4;
   localparam logic [2:0]  SEL_MAP1       = 3'h5;
   localparam logic [2:0]  SEL_MAP2       = 3'h6;
   localparam logic [2:0]  SEL_MAP3       = 3'h7;
   typedef enum logic [1:0] {
      PDU_OTHER   = 2'h0,
      PDU_TP_OAM  = 2'h1,
      PDU_ETH_OAM = 2'h2
   } payload_unit_type_t;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic               rule_hit;
      logic [6:0]         encapsulation_index;
      logic [4:0]         rule_pop_count;
      logic [4:0]         classifier_pop_count;
      logic [19:0]        inner_label;
      payload_unit_type_t payload_unit_type;
      logic               after_pop_is_control_word;
      logic [2:0]         classified_tc;
   } edit_req_t;
   typedef struct packed {
      logic [3:0][19:0]   map_label;
      logic [3:0][2:0]    map_tc;
      logic [3:0]         map_tc_hit;
   } map_result_t;
   typedef struct packed {
      logic [5:0]         pop_bytes;
      logic               push_valid;
      logic [47:0]        dmac;
      logic [47:0]        smac;
      logic [15:0]        etype;
      logic [2:0]         label_count;
      logic [3:0][31:0]   labels;
      logic               cw_valid;
      logic [31:0]        control_word;
   } edit_res_t;
endpackage

// ===== src/label_builder.sv
// One pushed label: value selection and inner label override.
`timescale 1ns/100ps
module label_builder (
   input  wire logic        [31:0]      i_value,
   input  wire logic        [2:0]       i_select,
   input  wire logic        [3:0][19:0] i_map_label,
   input  wire logic                    i_inner_use,
   input  wire logic        [19:0]      i_inner_label,
   output logic             [31:0]      o_label
);
   // ==========================================================
   // Label value selection
   logic [19:0] value;

   always_comb begin
      case (i_select)
         mpls_edit_pkg::SEL_MAP0: value = i_map_label[0];
         mpls_edit_pkg::SEL_MAP1: value = i_map_label[1];
         mpls_edit_pkg::SEL_MAP2: value = i_map_label[2];
         mpls_edit_pkg::SEL_MAP3: value = i_map_label[3];
         // Reserved codes fall back to the fixed value so output never depends on junk.
         default: value = i_value[31:mpls_edit_pkg::LBL_VAL_LSB];
      endcase
      if (i_inner_use) begin
         value = i_inner_label;
      end
      o_label = {value, i_value[mpls_edit_pkg::LBL_VAL_LSB-1:0]};
   end
endmodule

// ===== testbench/egress_port_model.sv
// Egress port stand-in: takes results, stalls on command, counts what it took.
`timescale 1ns/100ps
module egress_port_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_valid,
   input  wire logic        i_stall,
   output logic             o_ready,
   output logic [15:0]      o_taken
);
   initial begin
      o_ready = 1'b0;
      o_taken = '0;
   end
   // Ready only moves after an edge, so a stall lags the command by one cycle like a real port.
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_ready <= 1'b0;
         o_taken <= '0;
      end else begin
         o_ready <= !i_stall;
         if (i_valid && o_ready) begin
            o_taken <= o_taken + 16'h1;
         end
      end
   end
endmodule

// ===== testbench/mpls_egress_label_editor_tb.sv
// Self-checking bench for the egress label editor.
`timescale 1ns/100ps
module mpls_egress_label_editor_tb;
   typedef struct packed {
      logic hit; logic [6:0] idx; logic [4:0] rpop; logic [4:0] cpop; logic [1:0] pdu; logic acw;
      logic [5:0] epop; logic epush; logic [2:0] ecnt; logic ecw; logic [31:0] el0; logic [31:0] elast;
   } row_t;
   // ==========================================================
   // Signals
   logic                       ref_clk = 1'b0;
   logic                       sys_rst = 1'b1;
   logic                       psel = 1'b0;
   logic                       pen = 1'b0;
   logic                       pwr = 1'b0;
   logic [13:0]                paddr = '0;
   logic [31:0]                pwdata = '0;
   logic [31:0]                prdata;
   logic [31:0]                q;
   logic                       pready;
   logic                       pslverr;
   logic                       e;
   logic                       req_valid = 1'b0;
   logic                       req_ready;
   logic                       res_valid;
   logic                       res_ready;
   logic                       stall = 1'b0;
   logic [15:0]                taken;
   mpls_edit_pkg::edit_req_t   req = '0;
   mpls_edit_pkg::edit_res_t   res;
   mpls_edit_pkg::map_result_t map = {20'hf0003, 20'hf0002, 20'hf0001, 20'hf0000, 12'h8d1, 4'h1};
   logic [31:0]                stk [6] = '{0, 6, 13, 2, 4, 8};
   logic [31:0]                ext [6] = '{0, 0, 0, 5, 19, 21};
   int                         num_errors = 0;
   int                         num_checks = 0;
   row_t                       rows [8];
   row_t                       r;

   always #20 ref_clk = ~ref_clk;

   mpls_egress_label_editor dut_u (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_req_valid(req_valid), .i_req(req), .i_map(map), .o_req_ready(req_ready),
      .o_res_valid(res_valid), .o_res(res), .i_res_ready(res_ready));
   egress_port_model sink_u (.i_clk(ref_clk), .i_rst(sys_rst), .i_valid(res_valid), .i_stall(stall),
      .o_ready(res_ready), .o_taken(taken));

   // ==========================================================
   // Tasks
   function automatic logic [31:0] lv(input int n, input int k);
      return {12'h000, 4'(n), 4'(k), 12'h43f};
   endfunction
   function automatic logic [13:0] ea(input int n, input int w);
      return 14'((n << 6) + (w << 2));
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   // The master holds the request until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      pen <= 1'b1;
      @(posedge ref_clk);
      // Only the watchdog ends a wait for the answer.
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic send(input row_t x);
      req_valid <= 1'b1;
      req <= {x.hit, x.idx, x.rpop, x.cpop, 20'habcde, x.pdu, x.acw, 3'h6};
      @(posedge ref_clk);
      while (req_ready !== 1'b1) begin
         @(posedge ref_clk);
      end
      req_valid <= 1'b0;
      @(negedge ref_clk);
      chk("valid", 32'h1, 32'(res_valid));
      chk("pop", 32'(x.epop), 32'(res.pop_bytes));
      chk("push", 32'(x.epush), 32'(res.push_valid));
      if (x.epush) begin
         chk("count", 32'(x.ecnt), 32'(res.label_count));
         chk("dmac", 32'h11223300 | x.idx, res.dmac[31:0]);
         chk("dmac_hi", 32'h0000aa00 | x.idx, 32'(res.dmac[47:32]));
         chk("smac", 32'h44556600 | x.idx, res.smac[31:0]);
         chk("smac_hi", 32'h0000bb00 | x.idx, 32'(res.smac[47:32]));
         chk("etype", 32'h8847, 32'(res.etype));
         chk("cw_valid", 32'(x.ecw), 32'(res.cw_valid));
         if (x.ecw) begin
            chk("cw", 32'hc0de0000 | x.idx, res.control_word);
         end
         if (x.ecnt != 0) begin
            chk("label_first", x.el0, res.labels[0]);
            chk("label_last", x.elast, res.labels[x.ecnt - 1]);
         end
      end
      @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Sequence
   initial begin
      rows[0] = '{1, 1, 0, 4, 0, 0, 8, 1, 3, 0, lv(1, 0), lv(1, 2)};
      rows[1] = '{1, 2, 3, 6, 0, 0, 6, 1, 2, 1, lv(2, 0), {20'habcde, 12'h43f}};
      rows[2] = '{1, 3, 9, 5, 1, 0, 10, 1, 2, 0, 32'h0000db07, lv(3, 0)};
      rows[3] = '{1, 4, 21, 21, 2, 1, 42, 1, 3, 0, {20'hf0000, 12'h43f}, 32'h0000d307};
      rows[4] = '{1, 4, 0, 31, 2, 0, 42, 1, 2, 0, {20'hf0000, 12'h43f}, lv(4, 1)};
      rows[5] = '{1, 5, 0, 2, 1, 0, 4, 1, 0, 1, 0, 0};
      rows[6] = '{0, 1, 0, 3, 0, 0, 6, 0, 0, 0, 0, 0};
      rows[7] = '{1, 0, 0, 3, 0, 0, 6, 0, 0, 0, 0, 0};
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, mpls_edit_pkg::ADDR_CTRL, '0);
      chk("ctrl", mpls_edit_pkg::CTRL_RESET, q);
      for (int n = 1; n < 6; n++) begin
         wr(ea(n, 0), 32'h0000aa00 | n);
         wr(ea(n, 1), 32'h11223300 | n);
         wr(ea(n, 2), 32'h0000bb00 | n);
         wr(ea(n, 3), 32'h44556600 | n);
         wr(ea(n, 4), 32'h00008847);
         wr(ea(n, 5), stk[n]);
         wr(ea(n, 6), ext[n]);
         wr(ea(n, 7), 32'hc0de0000 | n);
         wr(ea(n, 11), 32'h0000db07);
         for (int k = 0; k < 3; k++) begin
            wr(ea(n, 8 + k), lv(n, k));
            wr(ea(n, 12 + k), (n == 4 && k < 2) ? 32'(4 >> (k * 2)) : 32'h0);
         end
      end
      foreach (rows[i]) begin
         send(rows[i]);
      end
      apb(1'b0, mpls_edit_pkg::ADDR_STATUS, '0);
      chk("status", 32'h00020006, q);
      wr(ea(6, 0), 32'hffffffff);
      apb(1'b0, ea(6, 0), '0);
      chk("dmac_high", 32'h0000ffff, q);
      apb(1'b0, 14'h2008, '0);
      chk("unmapped_err", 32'h1, 32'(e));
      wr(ea(0, 5), 32'h6);
      chk("entry0_err", 32'h1, 32'(e));
      stall <= 1'b1;
      @(posedge ref_clk);
      send(rows[2]);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("held_valid", 32'h1, 32'(res_valid));
      chk("held_ready", 32'h0, 32'(req_ready));
      chk("held_pop", 32'd10, 32'(res.pop_bytes));
      @(posedge ref_clk);
      stall <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("drained", 32'h0, 32'(res_valid));
      @(posedge ref_clk);
      wr(mpls_edit_pkg::ADDR_CTRL, 32'h0);
      r = rows[0];
      r.epush = 1'b0;
      send(r);
      @(negedge ref_clk);
      chk("taken", 32'd10, 32'(taken));
      tally_and_finish();
   end

   // Whole run needs well under 3000 cycles; the limit leaves ample slack.
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      tally_and_finish();
   end
endmodule
